// [logic/acrrd_top.sv]
/*
 alarm channel repeat relay and response delay, two channels per card.
 assumes field contacts and remote pushbuttons arrive asynchronously, the
 alarm sequence logic and lamp drive come from same-clock logic, and an
 axi4-lite master on the same clock.
*/
// Local design decisions: the AXI4-Lite register port and the register offsets.
//Contract
//- two relays, one per channel
//- idle coil select sets non-alarm coil
//- two mode bits pick follower type
//- input follower tracks qualified input
//- logic follower waits input and sequence reset
//- display follower copies lamp drive
//- standard build delay is 25ms
//- fixed build delay 1ms to 2s
//- adjustable ranges one, two, three
//- delay applies both directions
//- reset refused until return delay elapsed
//- ranges two/three may return immediately
//- six remote pushbuttons, active high
`timescale 1ns/1ps
module acrrd_top
	import acrrd_pkg::*;
#(
	parameter int unsigned CHANNELS     = 2,
	parameter bit          FIXED_BUILD  = 1'b0,
	parameter int unsigned FIXED_MS     = STD_DELAY_MS,
	parameter int unsigned MS_CYCLES    = MS_DIV
) (
	// clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                arst_n_i,
	// field contacts, already normalised to abnormal-high
	input  wire logic [CHANNELS-1:0] field_contact_i,
	// remote pushbuttons, high when tied to supply common
	input  wire logic [5:0]          remote_pb_i,
	// alarm sequence state and lamp drive per channel
	input  wire logic [CHANNELS-1:0] seq_reset_state_i,
	input  wire logic [CHANNELS-1:0] lamp_drive_i,
	// outputs to sequence logic
	output logic [CHANNELS-1:0]      qual_alarm_o,
	output logic [CHANNELS-1:0]      reset_allow_o,
	output logic [5:0]               pb_sync_o,
	// repeat relay coils
	output logic [CHANNELS-1:0]      relay_coil_o,
	// interrupt
	output logic                     irq_o,
	// axi4-lite slave
	input  wire logic [7:0]          s_awaddr_i,
	input  wire logic                s_awvalid_i,
	output logic                     s_awready_o,
	input  wire logic [31:0]         s_wdata_i,
	input  wire logic [3:0]          s_wstrb_i,
	input  wire logic                s_wvalid_i,
	output logic                     s_wready_o,
	output logic [1:0]               s_bresp_o,
	output logic                     s_bvalid_o,
	input  wire logic                s_bready_i,
	input  wire logic [7:0]          s_araddr_i,
	input  wire logic                s_arvalid_i,
	output logic                     s_arready_o,
	output logic [31:0]              s_rdata_o,
	output logic [1:0]               s_rresp_o,
	output logic                     s_rvalid_o,
	input  wire logic                s_rready_i
);
	initial begin
		if (CHANNELS != 2) $error("two channels per card only");
		if (FIXED_MS < FIX_MIN_MS || FIXED_MS > FIX_MAX_MS) $error("fixed delay out of range");
		if (MS_CYCLES < 1) $error("ms tick must be at least one cycle");
	end

	// reset release synchroniser
	logic       rst_s1_reg, rst_n;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// two-flop synchronisers for pins
	logic [CHANNELS-1:0] fc_s1_reg, fc_s2_reg;   // field contacts
	logic [5:0]          pb_s1_reg, pb_s2_reg;   // pushbuttons
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fc_s1_reg <= '0;
			fc_s2_reg <= '0;
			pb_s1_reg <= '0;
			pb_s2_reg <= '0;
		end else begin
			fc_s1_reg <= field_contact_i;
			fc_s2_reg <= fc_s1_reg;
			pb_s1_reg <= remote_pb_i;
			pb_s2_reg <= pb_s1_reg;
		end
	end
	assign pb_sync_o = pb_s2_reg;

	// millisecond tick divider
	logic [31:0] div_reg, div_next;
	logic        ms_tick;
	always_comb begin
		ms_tick  = (div_reg == 32'(MS_CYCLES - 1));
		div_next = ms_tick ? 32'h0 : div_reg + 32'h1;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) div_reg <= '0;
		else        div_reg <= div_next;
	end

	// software registers
	logic [31:0]         ctrl_reg;
	logic [15:0]         dly_reg [CHANNELS];
	logic [IRQ_W-1:0]    irq_reg, irq_next, mask_reg;
	logic [IRQ_W-1:0]    ev;

	// clamp a requested delay into the range of the fitted option
	function automatic logic [15:0] clamp_ms(input logic [1:0] rng, input logic [15:0] v);
		logic [15:0] lo, hi;
		lo = 16'(FIXED_MS);
		hi = 16'(FIXED_MS);
		unique case (rng)
			RNG_FIXED: begin lo = 16'(FIXED_MS);  hi = 16'(FIXED_MS);  end
			RNG_ONE:   begin lo = 16'(R1_MIN_MS); hi = 16'(R1_MAX_MS); end
			RNG_TWO:   begin lo = 16'(R2_MIN_MS); hi = 16'(R2_MAX_MS); end
			RNG_THREE: begin lo = 16'(R3_MIN_MS); hi = 16'(R3_MAX_MS); end
		endcase
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp_ms

	// per channel qualification and relay
	logic [CHANNELS-1:0] qual_reg, ret_ok_reg, relay_act;
	logic [CHANNELS-1:0] seq_done_reg;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic [15:0] cnt_reg, cnt_next, lim;
			logic        q_next, rok_next, sd_next;
			logic [1:0]  rng;
			logic        retsel, ma, mb, idle_sel;
			always_comb begin
				rng      = FIXED_BUILD ? RNG_FIXED : ctrl_reg[g*CTRL_STRIDE+CTRL_RANGE +: 2];
				retsel   = ctrl_reg[g*CTRL_STRIDE+CTRL_RETSEL];
				ma       = ctrl_reg[g*CTRL_STRIDE+CTRL_MODE_A];
				mb       = ctrl_reg[g*CTRL_STRIDE+CTRL_MODE_B];
				idle_sel = ctrl_reg[g*CTRL_STRIDE+CTRL_IDLE];
				lim      = clamp_ms(rng, dly_reg[g]);
				q_next   = qual_reg[g];
				cnt_next = cnt_reg;
				rok_next = ret_ok_reg[g];
				if (fc_s2_reg[g] == qual_reg[g]) begin
					cnt_next = '0;      // no pending change
				end else if (!fc_s2_reg[g] && retsel
						&& (rng == RNG_TWO || rng == RNG_THREE)) begin
					q_next   = 1'b0;    // immediate return
					cnt_next = '0;
				end else if (ms_tick) begin
					if (cnt_reg + 16'h1 >= lim) begin
						q_next   = fc_s2_reg[g]; // persisted full delay
						cnt_next = '0;
					end else begin
						cnt_next = cnt_reg + 16'h1;
					end
				end
				rok_next = !q_next;     // reset only after qualified return
				// logic follower latch: held until sequence reset and input normal
				sd_next  = q_next ? 1'b0
					: (seq_reset_state_i[g] ? 1'b1 : seq_done_reg[g]);
				unique case ({ma, mb})
					2'b10:   relay_act[g] = !seq_done_reg[g] || qual_reg[g];
					2'b11:   relay_act[g] = lamp_drive_i[g];
					default: relay_act[g] = qual_reg[g];
				endcase
			end
			always_ff @(posedge ref_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					cnt_reg         <= '0;
					qual_reg[g]     <= 1'b0;
					ret_ok_reg[g]   <= 1'b1;
					seq_done_reg[g] <= 1'b1;
				end else begin
					cnt_reg         <= cnt_next;
					qual_reg[g]     <= q_next;
					ret_ok_reg[g]   <= rok_next;
					seq_done_reg[g] <= sd_next;
				end
			end
			// coil energised when idle unless idle select set
			always_ff @(posedge ref_clk_i or negedge rst_n) begin
				if (!rst_n) relay_coil_o[g] <= 1'b0;
				else        relay_coil_o[g] <= relay_act[g] ? idle_sel : !idle_sel;
			end
		end
	endgenerate
	assign qual_alarm_o  = qual_reg;
	assign reset_allow_o = ret_ok_reg;

	// events: alarm rise and qualified return per channel
	logic [CHANNELS-1:0] qual_d_reg;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) qual_d_reg <= '0;
		else        qual_d_reg <= qual_reg;
	end
	assign ev = {qual_d_reg & ~qual_reg, qual_reg & ~qual_d_reg};

	// axi4-lite: write when both address and data present
	logic        bvalid_reg, rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic        wr_go, rd_go, rd_irq;
	assign wr_go       = s_awvalid_i && s_wvalid_i && !bvalid_reg;
	assign s_awready_o = wr_go;
	assign s_wready_o  = wr_go;
	assign rd_go       = s_arvalid_i && !rvalid_reg;
	assign s_arready_o = rd_go;
	assign rd_irq      = rd_go && (s_araddr_i == OFS_IRQ);

	// sticky status, set wins over read clear
	always_comb irq_next = (rd_irq ? '0 : irq_reg) | ev;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) irq_reg <= '0;
		else        irq_reg <= irq_next;
	end
	assign irq_o = |(irq_reg & mask_reg);

	// byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction : merge

	// write side registers
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg   <= CTRL_RST;
			dly_reg[0] <= DLY_RST;
			dly_reg[1] <= DLY_RST;
			mask_reg   <= MASK_RST[IRQ_W-1:0];
			bvalid_reg <= 1'b0;
			bresp_reg  <= 2'h0;
		end else begin
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= 2'h0;
				unique case (s_awaddr_i)
					OFS_CTRL: ctrl_reg   <= merge(ctrl_reg, s_wdata_i, s_wstrb_i);
					OFS_DLY0: dly_reg[0] <= 16'(merge({16'h0, dly_reg[0]},
						s_wdata_i, s_wstrb_i));
					OFS_DLY1: dly_reg[1] <= 16'(merge({16'h0, dly_reg[1]},
						s_wdata_i, s_wstrb_i));
					OFS_MASK: mask_reg   <= IRQ_W'(merge({28'h0, mask_reg},
						s_wdata_i, s_wstrb_i));
					OFS_STAT, OFS_IRQ: bresp_reg <= 2'h0;
					default:  bresp_reg  <= 2'h2;
				endcase
			end else if (s_bready_i) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read side
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= 2'h0;
		end else begin
			if (rd_go) begin
				rvalid_reg <= 1'b1;
				rresp_reg  <= 2'h0;
				unique case (s_araddr_i)
					OFS_CTRL: rdata_reg <= ctrl_reg;
					OFS_DLY0: rdata_reg <= {16'h0, dly_reg[0]};
					OFS_DLY1: rdata_reg <= {16'h0, dly_reg[1]};
					OFS_STAT: rdata_reg <= {18'h0, pb_s2_reg,
						1'b0, ret_ok_reg[1], relay_coil_o[1], qual_reg[1],
						1'b0, ret_ok_reg[0], relay_coil_o[0], qual_reg[0]};
					OFS_IRQ:  rdata_reg <= {28'h0, irq_reg};
					OFS_MASK: rdata_reg <= {28'h0, mask_reg};
					default: begin
						rdata_reg <= '0;
						rresp_reg <= 2'h2;
					end
				endcase
			end else if (s_rready_i) begin
				rvalid_reg <= 1'b0;
			end
		end
	end
	assign s_bvalid_o = bvalid_reg;
	assign s_bresp_o  = bresp_reg;
	assign s_rvalid_o = rvalid_reg;
	assign s_rdata_o  = rdata_reg;
	assign s_rresp_o  = rresp_reg;

	// checks
	qual_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		$rose(qual_reg[0]) |-> $past(fc_s2_reg[0])) else $error("alarm without input");
	reset_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		reset_allow_o[0] |-> !qual_reg[0]) else $error("reset allowed in alarm");
	// coil was registered with the idle select of the previous cycle
	input_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(ctrl_reg[2:1] == 2'b00 && $stable(ctrl_reg)) |=>
		relay_coil_o[0] == ($past(qual_reg[0]) ^ !$past(ctrl_reg[0])))
		else $error("input follow");
	// logic follower keeps the relay active past the drop of qual until reset seen
	logic_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(ctrl_reg[2:1] == 2'b01 && $stable(ctrl_reg) && $past(qual_reg[0])
		&& !$past(seq_reset_state_i[0])) |=> relay_coil_o[0] == $past(ctrl_reg[0]))
		else $error("logic follow released early");
	display_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(ctrl_reg[2:1] == 2'b11 && $stable(ctrl_reg)) |=>
		relay_coil_o[0] == ($past(lamp_drive_i[0]) ^ !$past(ctrl_reg[0])))
		else $error("display follow");
	// pushbuttons come out two clocks after the pin
	pb_sync_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		pb_sync_o == $past(remote_pb_i, 2)) else $error("pushbutton sync");
	// an alarm event always lands in the sticky bit, even against a clearing read
	irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		ev[0] |=> irq_reg[0]) else $error("irq event lost");
	alarm_cov_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(qual_reg[0]));
	return_cov_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $fell(qual_reg[1]));
	irq_cov_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(irq_o));
endmodule : acrrd_top

// [logic/acrrd_pkg.sv]
/*
 package for the alarm channel repeat relay and response delay block:
 register map, field positions, reset values and timing constants.
 assumes a 40 MHz system clock.
*/
package acrrd_pkg;
	// clock rate
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	// response times in ms
	localparam int unsigned STD_DELAY_MS  = 25;
	localparam int unsigned FIX_MIN_MS    = 1;
	localparam int unsigned FIX_MAX_MS    = 2000;
	localparam int unsigned R1_MIN_MS     = 5;
	localparam int unsigned R1_MAX_MS     = 50;
	localparam int unsigned R2_MIN_MS     = 25;
	localparam int unsigned R2_MAX_MS     = 2000;
	localparam int unsigned R3_MIN_MS     = 5;
	localparam int unsigned R3_MAX_MS     = 5000;
	// ms tick divider count
	localparam int unsigned MS_DIV        = CYC_PER_MS;
	// delay ranges
	localparam logic [1:0]  RNG_FIXED     = 2'h0;
	localparam logic [1:0]  RNG_ONE       = 2'h1;
	localparam logic [1:0]  RNG_TWO       = 2'h2;
	localparam logic [1:0]  RNG_THREE     = 2'h3;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_DLY0      = 8'h04;
	localparam logic [7:0]  OFS_DLY1      = 8'h08;
	localparam logic [7:0]  OFS_STAT      = 8'h0c;
	localparam logic [7:0]  OFS_IRQ       = 8'h10;
	localparam logic [7:0]  OFS_MASK      = 8'h14;
	// ctrl fields, per channel base = 8*ch
	localparam int unsigned CTRL_IDLE     = 0;
	localparam int unsigned CTRL_MODE_A   = 1;
	localparam int unsigned CTRL_MODE_B   = 2;
	localparam int unsigned CTRL_RANGE    = 3;
	localparam int unsigned CTRL_RETSEL   = 5;
	localparam int unsigned CTRL_STRIDE   = 8;
	// reset values
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [15:0] DLY_RST       = 16'h0019;
	localparam logic [31:0] MASK_RST      = 32'h0000_0000;
	// status bits per channel: qualified, relay, reset_ok, stride 4
	localparam int unsigned STAT_STRIDE   = 4;
	// irq bits: alarm rise ch0/1, return ch0/1
	localparam int unsigned IRQ_W         = 4;
	// relay modes
	typedef enum logic [1:0] {
		ACRRD_IN_FOLLOW  = 2'b00,
		ACRRD_LOG_FOLLOW = 2'b01,
		ACRRD_DSP_FOLLOW = 2'b10
	} acrrd_mode_e;
endpackage : acrrd_pkg

// [sim/acrrd_field_model.sv]
/*
 field side model: alarm contacts and relay receivers, two channels.
 assumes the bench commands contact states on the system clock.
*/
`timescale 1ns/1ps
module acrrd_field_model (
	// clock
	input  wire logic       clk_i,
	// commanded contact state, high = abnormal, and chatter request
	input  wire logic [1:0] want_abn_i,
	input  wire logic [1:0] chatter_i,
	// relay coils and idle coil select
	input  wire logic [1:0] coil_i,
	input  wire logic [1:0] idle_sel_i,
	// contact lines and receiver alarm view
	output logic      [1:0] contact_o,
	output logic      [1:0] seen_alarm_o
);
	initial contact_o = 2'h0;
	// contact moves after an edge; chatter bounces it every cycle
	always @(posedge clk_i) begin
		contact_o <= (chatter_i & ~contact_o) | (~chatter_i & want_abn_i);
	end
	// receiver decodes alarm from coil and idle select
	assign seen_alarm_o = ~(coil_i ^ idle_sel_i);
	// lamp drive is read as a plain led level, drive type switch off
endmodule : acrrd_field_model

// [sim/testbench.sv]
/*
 self-checking bench for the repeat relay and response delay block.
 assumes MS_CYCLES is set to 4, so one ms is four clocks.
*/
`timescale 1ns/1ps
module testbench
	import acrrd_pkg::*;
;
	localparam int MSC = 4; // clocks per ms in sim
	// one mode row: ctrl byte, contact, seq reset, lamp, relay alarm
	typedef struct packed {
		logic [7:0] ctl;
		logic       abn;
		logic       seq;
		logic       lmp;
		logic       act;
	} acrrd_row_s;
	acrrd_row_s rows [10] = '{
		'{8'h04, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'h04, 1'b0, 1'b0, 1'b0, 1'b0},
		'{8'h05, 1'b1, 1'b0, 1'b0, 1'b1}, '{8'h00, 1'b1, 1'b0, 1'b0, 1'b1},
		'{8'h00, 1'b0, 1'b0, 1'b0, 1'b0}, '{8'h06, 1'b0, 1'b0, 1'b1, 1'b1},
		'{8'h06, 1'b1, 1'b0, 1'b0, 1'b0}, '{8'h02, 1'b1, 1'b0, 1'b0, 1'b1},
		'{8'h02, 1'b0, 1'b0, 1'b0, 1'b1}, '{8'h02, 1'b0, 1'b1, 1'b0, 1'b0}};
	// range rows: ctrl, delay reg, rise ms, return ms
	int rng [4][4] = '{'{8'h1c, 5, 5, 5}, '{8'h3c, 5, 5, 0}, '{8'h0c, 100, 50, 50},
		'{8'h14, 10, 25, 25}};
	// clock, reset, bus
	logic        ref_clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [7:0]  s_awaddr_i = 8'h00, s_araddr_i = 8'h00;
	logic [31:0] s_wdata_i = 32'h0, s_rdata_o;
	logic [3:0]  s_wstrb_i = 4'hf;
	logic        s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
	logic        s_arvalid_i = 1'b0, s_rready_i = 1'b0;
	logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq;
	logic [1:0]  s_bresp_o, s_rresp_o;
	// field, sequence and relay side
	logic [1:0]  want = 2'h0, chat = 2'h0, idle = 2'h0, seq = 2'h0, lamp = 2'h0;
	logic [1:0]  contact, seen, qual, rallow, coil;
	logic [5:0]  pb = 6'h00, pb_sync;
	int          err_total = 0, compares = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	acrrd_top #(.MS_CYCLES(MSC)) acrrd_top_inst (.ref_clk_i, .arst_n_i,
		.field_contact_i(contact), .remote_pb_i(pb), .seq_reset_state_i(seq),
		.lamp_drive_i(lamp), .qual_alarm_o(qual), .reset_allow_o(rallow), .pb_sync_o(pb_sync),
		.relay_coil_o(coil), .irq_o(irq), .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
		.s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
		.s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i);
	acrrd_field_model acrrd_field_model_inst (.clk_i(ref_clk_i), .want_abn_i(want),
		.chatter_i(chat), .coil_i(coil), .idle_sel_i(idle), .contact_o(contact),
		.seen_alarm_o(seen));
	// verdict and end of run
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	// value compare
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got %h want %h", $time, got, exp);
		end
	endtask : cmp
	// delay compare: tick alignment early, sync and registers late
	task automatic cmp_win(input int n, input int e);
		compares++;
		if (n < e - MSC || n > e + 12) begin
			err_total++;
			$display("[ERR] t=%0t delay %0d clocks, want about %0d", $time, n, e);
		end
	endtask : cmp_win
	// bounded wait on a handshake: 0 aw/w ready, 1 bvalid, 2 arready, 3 rvalid
	task automatic wt(input int s);
		int   n;
		logic v;
		n = 0;
		v = 1'b0;
		while (v !== 1'b1) begin
			@(negedge ref_clk_i);
			v = (s == 0) ? s_awready_o : (s == 1) ? s_bvalid_o : (s == 2) ? s_arready_o : s_rvalid_o;
			n++;
			if (n > 99) begin
				err_total++;
				$display("[ERR] t=%0t bus handshake timeout", $time);
				print_verdict();
			end
		end
	endtask : wt
	// bounded wait for qualified ch0 to reach a level, counting clocks
	task automatic meas(input logic lvl, output int n);
		n = 0;
		while (qual[0] !== lvl) begin
			@(negedge ref_clk_i);
			n++;
			if (n > 2000) begin
				err_total++;
				$display("[ERR] t=%0t qualify timeout", $time);
				print_verdict();
			end
		end
	endtask : meas
	// axi4-lite write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_i);
		s_awaddr_i  <= a;
		s_wdata_i   <= d;
		s_awvalid_i <= 1'b1;
		s_wvalid_i  <= 1'b1;
		s_bready_i  <= 1'b1;
		wt(0);
		@(posedge ref_clk_i);
		s_awvalid_i <= 1'b0;
		s_wvalid_i  <= 1'b0;
		wt(1);
		r = s_bresp_o;
		@(posedge ref_clk_i);
		s_bready_i <= 1'b0;
	endtask : axi_wr
	// axi4-lite read
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_i);
		s_araddr_i  <= a;
		s_arvalid_i <= 1'b1;
		s_rready_i  <= 1'b1;
		wt(2);
		@(posedge ref_clk_i);
		s_arvalid_i <= 1'b0;
		wt(3);
		d = s_rdata_o;
		r = s_rresp_o;
		@(posedge ref_clk_i);
		s_rready_i <= 1'b0;
	endtask : axi_rd
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		repeat (10) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (6) @(negedge ref_clk_i);
		cmp(32'(coil), 32'h3);
		cmp(32'(rallow), 32'h3);
		axi_rd(OFS_CTRL, d, r);
		cmp(d, CTRL_RST);
		axi_rd(OFS_DLY1, d, r);
		cmp(d, 32'(DLY_RST));
		axi_rd(OFS_MASK, d, r);
		cmp(d, MASK_RST);
		axi_rd(8'h18, d, r);
		cmp(32'(r), 32'h2);
		axi_wr(8'h18, 32'h0, r);
		cmp(32'(r), 32'h2);
		$display("reset test done");
		// mode table on both channels
		foreach (rows[i]) begin
			axi_wr(OFS_CTRL, {16'h0, rows[i].ctl, rows[i].ctl}, r);
			cmp(32'(r), 32'h0);
			want <= {2{rows[i].abn}};
			seq  <= {2{rows[i].seq}};
			lamp <= {2{rows[i].lmp}};
			idle <= {2{rows[i].ctl[0]}};
			repeat (130) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			cmp(32'(seen), 32'({2{rows[i].act}}));
			cmp(32'(qual), 32'({2{rows[i].abn}}));
		end
		$display("mode table done");
		// standard delay both ways, reset hold-off, interrupt mask and clear
		axi_wr(OFS_CTRL, 32'h0404, r);
		axi_wr(OFS_MASK, 32'h1, r);
		axi_rd(OFS_IRQ, d, r);
		want <= 2'b01;
		meas(1'b1, n);
		cmp_win(n, int'(STD_DELAY_MS) * MSC);
		repeat (3) @(negedge ref_clk_i);
		cmp(32'(irq), 32'h1);
		axi_rd(OFS_IRQ, d, r);
		cmp(d & 32'hf, 32'h1);
		@(negedge ref_clk_i);
		cmp(32'(irq), 32'h0);
		// status: ch0 qualified with coil at alarm level, ch1 idle and energised
		axi_rd(OFS_STAT, d, r);
		cmp(d, 32'h0000_0061);
		@(posedge ref_clk_i);
		want <= 2'b00;
		repeat (50) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		cmp(32'(rallow[0]), 32'h0);
		cmp(32'(qual[0]), 32'h1);
		meas(1'b0, n);
		cmp_win(n + 51, int'(STD_DELAY_MS) * MSC);
		repeat (3) @(negedge ref_clk_i);
		cmp(32'(rallow[0]), 32'h1);
		cmp(32'(irq), 32'h0);
		axi_rd(OFS_IRQ, d, r);
		cmp(d & 32'hf, 32'h4);
		// chatter never persists long enough
		chat <= 2'b11;
		repeat (300) @(posedge ref_clk_i);
		chat <= 2'b00;
		@(negedge ref_clk_i);
		cmp(32'(qual), 32'h0);
		$display("delay test done");
		// adjustable ranges, clamping and immediate return
		foreach (rng[i]) begin
			axi_wr(OFS_DLY0, 32'(rng[i][1]), r);
			axi_wr(OFS_CTRL, 32'(rng[i][0]), r);
			repeat (8) @(posedge ref_clk_i);
			want <= 2'b01;
			meas(1'b1, n);
			cmp_win(n, rng[i][2] * MSC);
			@(posedge ref_clk_i);
			want <= 2'b00;
			meas(1'b0, n);
			cmp_win(n, rng[i][3] * MSC);
		end
		$display("range test done");
		// mid-run reset with ch0 in alarm
		@(posedge ref_clk_i);
		want <= 2'b01;
		meas(1'b1, n);
		@(posedge ref_clk_i);
		arst_n_i <= 1'b0;
		want     <= 2'b00;
		@(negedge ref_clk_i);
		cmp(32'({coil, qual, irq}), 32'h0);
		cmp(32'(rallow), 32'h3);
		repeat (10) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (6) @(negedge ref_clk_i);
		cmp(32'(coil), 32'h3);
		cmp(32'(qual), 32'h0);
		axi_rd(OFS_CTRL, d, r);
		cmp(d, CTRL_RST);
		$display("mid-run reset test done");
		// each remote pushbutton alone
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk_i);
			pb <= 6'(1 << i);
			repeat (4) @(negedge ref_clk_i);
			cmp(32'(pb_sync), 32'(1 << i));
		end
		$display("pushbutton test done");
		print_verdict();
	end
endmodule : testbench
